// *** shared/sacc_pkg.sv ***
`default_nettype none
package sacc_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ACCUM = 4'h1;
  localparam logic [3:0] OFS_CLKDIV = 4'h2;
  localparam logic [3:0] OFS_SAMPLE = 4'h3;
  localparam logic [3:0] OFS_CHAN = 4'h4;
  localparam logic [3:0] OFS_REF = 4'h5;
  localparam logic [3:0] OFS_EVCTRL = 4'h6;
  localparam logic [3:0] OFS_COMMAND = 4'h7;
  localparam logic [3:0] OFS_INTCTRL = 4'h8;
  localparam logic [3:0] OFS_INTFLAG = 4'h9;
  localparam logic [3:0] OFS_RESULT = 4'ha;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FREE_RUNNING_BIT = 1;
  localparam int CTRL_RES8_BIT = 2;
  localparam int CTRL_DEBUG_BIT = 3;
  localparam int SAMPLE_DLY_LSB = 0;
  localparam int SAMPLE_LEN_LSB = 4;

  // ************************************************************
  // reset values, timing counts and accumulation limit
  // ************************************************************
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [2:0] ACCUM_RESET = 3'h0;
  localparam logic [2:0] CLKDIV_RESET = 3'h0;
  localparam logic [5:0] CONV_CYCLES = 6'h0d;
  localparam logic [5:0] SAMPLE_BASE = 6'h02;
  localparam logic [2:0] ACCUM_MAX_SEL = 3'h6;

  typedef enum logic [1:0] {
    SACC_IDLE = 2'b00,
    SACC_SYNC = 2'b01,
    SACC_CONV = 2'b11
  } sacc_state_t;
endpackage
`default_nettype wire

// *** src/sacc_top.sv ***
`default_nettype none
module sacc_top
  import sacc_pkg::*;
#(
  parameter int CH_W = 5,
  parameter int REF_W = 3
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic EVENT_IN,
  input wire logic CPU_HALTED,
  input wire logic [9:0] CORE_RESULT,
  output logic [CH_W-1:0] CHANNEL_ACTIVE,
  output logic [REF_W-1:0] REFERENCE_ACTIVE,
  output logic CONV_CLK,
  output logic SAMPLE_HOLD,
  output logic CONV_BUSY,
  output logic IRQ
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    sacc_state_t st;
    logic en;
    logic free;
    logic res8;
    logic dbg;
    logic [2:0] accn;
    logic [2:0] clock_divider_select;
    logic [3:0] sdly;
    logic [3:0] slen;
    logic [CH_W-1:0] chan_tmp;
    logic [REF_W-1:0] ref_tmp;
    logic [CH_W-1:0] chan_act;
    logic [REF_W-1:0] ref_act;
    logic evstart;
    logic start;
    logic rrie;
    logic rrflag;
    logic [15:0] result;
    logic [7:0] pcnt;
    logic [5:0] cyc;
    logic [6:0] nleft;
    logic [15:0] acc;
    logic ev_prev;
    logic [15:0] rdata;
    logic irq;
    logic sh;
    logic busy;
    logic cclk;
  } sacc_regs_t;

  sacc_regs_t s_reg;
  sacc_regs_t s_next;

  // ************************************************************
  // derived timing
  // ************************************************************
  logic [7:0] half;
  logic [7:0] factor_m1;
  logic [5:0] samp_end;
  logic [5:0] conv_total;
  logic [6:0] samples;
  logic run;
  logic tick;
  logic ev_rise;
  logic [15:0] sample_val;
  logic [15:0] acc_sum;
  logic locked;

  always_comb begin
    half = 8'h01 << s_reg.clock_divider_select;
    factor_m1 = (half << 1) - 8'h01;
    samp_end = SAMPLE_BASE + {2'b00, s_reg.sdly} + {2'b00, s_reg.slen};
    conv_total = CONV_CYCLES + {2'b00, s_reg.sdly} + {2'b00, s_reg.slen};
    samples = 7'h01 << s_reg.accn;
    // frozen under a debugger halt unless told to keep going
    run = s_reg.en & (~CPU_HALTED | s_reg.dbg);
    tick = (s_reg.st != SACC_IDLE) && (s_reg.pcnt == half - 8'h01);
    ev_rise = EVENT_IN & ~s_reg.ev_prev;
    // reduced resolution keeps the top bits, still right-adjusted
    sample_val = s_reg.res8 ? {8'h00, CORE_RESULT[9:2]} : {6'h00, CORE_RESULT};
    acc_sum = s_reg.acc + sample_val;
    // selection frozen from start up to the last converter cycle
    locked = (s_reg.st == SACC_CONV) && (s_reg.cyc < conv_total - 6'h01);
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.sh = 1'b0;
    s_next.rdata = 16'h0000;
    s_next.ev_prev = EVENT_IN;

    // flag clears go first so a same-cycle completion still sets it
    if (WR && ADDR == OFS_INTFLAG && WDATA[0]) begin
      s_next.rrflag = 1'b0;
    end
    if (RD && ADDR == OFS_RESULT) begin
      s_next.rrflag = 1'b0;
    end

    if (!s_reg.en) begin
      // abandon without touching result or flag
      s_next.st = SACC_IDLE;
      s_next.start = 1'b0;
      s_next.pcnt = 8'h00;
      s_next.cyc = 6'h00;
    end else if (run) begin
      if (s_reg.st == SACC_IDLE) begin
        s_next.pcnt = 8'h00;
      end else if (s_reg.pcnt == factor_m1) begin
        s_next.pcnt = 8'h00;
      end else begin
        s_next.pcnt = s_reg.pcnt + 8'h01;
      end
      case (s_reg.st)
        SACC_IDLE: begin
          if (s_reg.start) begin
            s_next.st = SACC_SYNC;
          end
        end
        SACC_SYNC: begin
          if (tick) begin
            s_next.st = SACC_CONV;
            s_next.cyc = 6'h00;
            s_next.nleft = samples;
            s_next.acc = 16'h0000;
          end
        end
        SACC_CONV: begin
          if (tick) begin
            s_next.cyc = s_reg.cyc + 6'h01;
            if (s_reg.cyc == samp_end - 6'h01) begin
              s_next.sh = 1'b1;
            end
            if (s_reg.cyc == conv_total - 6'h01) begin
              s_next.cyc = 6'h00;
              if (s_reg.nleft > 7'h01) begin
                // next sample of the burst follows with no gap
                s_next.nleft = s_reg.nleft - 7'h01;
                s_next.acc = acc_sum;
              end else begin
                s_next.result = acc_sum;
                s_next.rrflag = 1'b1;
                s_next.acc = 16'h0000;
                s_next.nleft = samples;
                if (!(s_reg.free && s_reg.start)) begin
                  s_next.start = 1'b0;
                  s_next.st = SACC_IDLE;
                  s_next.pcnt = 8'h00;
                end
                // otherwise stay converting: restart at once
              end
            end
          end
        end
        default: begin
          s_next.st = SACC_IDLE;
        end
      endcase
    end

    // selections copy through unless a conversion holds them
    if (!(locked || s_reg.st == SACC_SYNC && tick)) begin
      s_next.chan_act = s_reg.chan_tmp;
      s_next.ref_act = s_reg.ref_tmp;
    end

    // start requests after the hardware clear so a new request is not lost
    if (s_reg.en && s_reg.evstart && ev_rise) begin
      s_next.start = 1'b1;
    end

    if (WR) begin
      case (ADDR)
        OFS_CTRL: begin
          s_next.en = WDATA[CTRL_ENABLE_BIT];
          s_next.free = WDATA[CTRL_FREE_RUNNING_BIT];
          s_next.res8 = WDATA[CTRL_RES8_BIT];
          s_next.dbg = WDATA[CTRL_DEBUG_BIT];
        end
        OFS_ACCUM: begin
          s_next.accn = (WDATA[2:0] > ACCUM_MAX_SEL) ? ACCUM_MAX_SEL : WDATA[2:0];
        end
        OFS_CLKDIV: begin
          s_next.clock_divider_select = WDATA[2:0];
        end
        OFS_SAMPLE: begin
          s_next.sdly = WDATA[SAMPLE_DLY_LSB +: 4];
          s_next.slen = WDATA[SAMPLE_LEN_LSB +: 4];
        end
        OFS_CHAN: begin
          s_next.chan_tmp = WDATA[CH_W-1:0];
        end
        OFS_REF: begin
          s_next.ref_tmp = WDATA[REF_W-1:0];
        end
        OFS_EVCTRL: begin
          s_next.evstart = WDATA[0];
        end
        OFS_COMMAND: begin
          if (WDATA[0] && s_reg.en) begin
            s_next.start = 1'b1;
          end
        end
        OFS_INTCTRL: begin
          s_next.rrie = WDATA[0];
        end
        default: begin
        end
      endcase
    end

    if (RD) begin
      case (ADDR)
        OFS_CTRL: begin
          s_next.rdata = {12'h000, s_reg.dbg, s_reg.res8, s_reg.free, s_reg.en};
        end
        OFS_ACCUM: begin
          s_next.rdata = {13'h0000, s_reg.accn};
        end
        OFS_CLKDIV: begin
          s_next.rdata = {13'h0000, s_reg.clock_divider_select};
        end
        OFS_SAMPLE: begin
          s_next.rdata = {8'h00, s_reg.slen, s_reg.sdly};
        end
        OFS_CHAN: begin
          s_next.rdata = 16'(s_reg.chan_tmp);
        end
        OFS_REF: begin
          s_next.rdata = 16'(s_reg.ref_tmp);
        end
        OFS_EVCTRL: begin
          s_next.rdata = {15'h0000, s_reg.evstart};
        end
        OFS_COMMAND: begin
          s_next.rdata = {15'h0000, s_reg.start};
        end
        OFS_INTCTRL: begin
          s_next.rdata = {15'h0000, s_reg.rrie};
        end
        OFS_INTFLAG: begin
          s_next.rdata = {15'h0000, s_reg.rrflag};
        end
        OFS_RESULT: begin
          s_next.rdata = s_reg.result;
        end
        default: begin
          s_next.rdata = 16'h0000;
        end
      endcase
    end

    s_next.irq = s_next.rrflag & s_next.rrie;
    s_next.busy = (s_next.st == SACC_CONV);
    s_next.cclk = (s_next.st != SACC_IDLE) && (s_next.pcnt >= half);
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      s_reg <= '{
        st: SACC_IDLE,
        accn: ACCUM_RESET,
        clock_divider_select: CLKDIV_RESET,
        result: RESULT_RESET,
        nleft: 7'h01,
        default: '0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata;
  assign CHANNEL_ACTIVE = s_reg.chan_act;
  assign REFERENCE_ACTIVE = s_reg.ref_act;
  assign CONV_CLK = s_reg.cclk;
  assign SAMPLE_HOLD = s_reg.sh;
  assign CONV_BUSY = s_reg.busy;
  assign IRQ = s_reg.irq;

endmodule // sacc_top
`default_nettype wire

// *** test/sacc_core_model.sv ***
`default_nettype none
module sacc_core_model #(
  parameter int CH_W = 5
) (
  input wire logic clk,
  input wire logic sample_hold,
  input wire logic busy,
  input wire logic [CH_W-1:0] channel,
  output logic [9:0] code
);
  timeunit 1ns;
  timeprecision 1ps;
  // code tracks the channel held at the sample instant; once idle it shows the inverse,
  // so a stale sample is never mistaken for a fresh one
  always @(posedge clk) begin
    if (sample_hold) begin
      code <= 10'({channel, channel});
    end else if (!busy) begin
      code <= 10'(~{channel, channel});
    end
  end
endmodule // sacc_core_model
`default_nettype wire

// *** test/sacc_checker.sv ***
`default_nettype none
module sacc_checker
  import sacc_pkg::*;
#(
  parameter int CH_W = 5,
  parameter int REF_W = 3
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic EVENT_IN,
  input wire logic CPU_HALTED,
  input wire logic [9:0] CORE_RESULT,
  input wire logic [CH_W-1:0] CHANNEL_ACTIVE,
  input wire logic [REF_W-1:0] REFERENCE_ACTIVE,
  input wire logic CONV_CLK,
  input wire logic SAMPLE_HOLD,
  input wire logic CONV_BUSY,
  input wire logic IRQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence s_start; $rose(CONV_BUSY); endsequence
  sequence s_locked; ($stable(CHANNEL_ACTIVE) && $stable(REFERENCE_ACTIVE))[*8]; endsequence
  property p_sh_busy; SAMPLE_HOLD |-> CONV_BUSY; endproperty
  property p_sh_pulse; SAMPLE_HOLD |=> !SAMPLE_HOLD; endproperty
  property p_busy_min; s_start |-> CONV_BUSY[*8]; endproperty
  property p_sh_soon; s_start |-> ##[1:300] SAMPLE_HOLD; endproperty
  property p_lock; s_start |=> s_locked; endproperty
  property p_irq_hold; IRQ && !WR && !RD && !$past(RD) && !$past(RD, 2) |=> IRQ; endproperty
  property p_irq_drop; RD && ADDR == OFS_RESULT && !CONV_BUSY |-> ##2 !IRQ; endproperty
  property p_clk_idle; !CONV_BUSY && !$past(CONV_BUSY) |-> !CONV_CLK; endproperty
  a_sh_busy: assert property (p_sh_busy) else $error("sample pulse while idle");
  a_sh_pulse: assert property (p_sh_pulse) else $error("sample pulse too long");
  a_busy_min: assert property (p_busy_min) else $error("conversion too short");
  a_sh_soon: assert property (p_sh_soon) else $error("no sample instant");
  a_lock: assert property (p_lock) else $error("selection moved in conversion");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped on its own");
  a_irq_drop: assert property (p_irq_drop) else $error("irq kept after read");
  a_clk_idle: assert property (p_clk_idle) else $error("converter clock idle high");
endmodule // sacc_checker

bind sacc_top sacc_checker #(.CH_W(CH_W), .REF_W(REF_W)) u_chk (
  .REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .EVENT_IN(EVENT_IN), .CPU_HALTED(CPU_HALTED), .CORE_RESULT(CORE_RESULT),
  .CHANNEL_ACTIVE(CHANNEL_ACTIVE), .REFERENCE_ACTIVE(REFERENCE_ACTIVE), .CONV_CLK(CONV_CLK),
  .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_BUSY(CONV_BUSY), .IRQ(IRQ));
`default_nettype wire

// *** test/sacc_top_tb.sv ***
`default_nettype none
module sacc_top_tb
  import sacc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr, rd, ev, halt, conv_clk, sh, busy, irq, dbg, r8;
  logic [3:0] addr, dl, ln;
  logic [15:0] wdata, rdata, v;
  logic [9:0] core;
  logic [4:0] ch, c2, ch_act;
  logic [2:0] ref_act, pr;
  logic [31:0] lf;
  int fail_count = 0, check_count = 0, i, n, lat, len;
  always #2.5 clk = ~clk;
  sacc_top dut (.REF_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .EVENT_IN(ev), .CPU_HALTED(halt), .CORE_RESULT(core),
    .CHANNEL_ACTIVE(ch_act), .REFERENCE_ACTIVE(ref_act), .CONV_CLK(conv_clk),
    .SAMPLE_HOLD(sh), .CONV_BUSY(busy), .IRQ(irq));
  sacc_core_model #(.CH_W(5)) u_core (.clk(clk), .sample_hold(sh), .busy(busy),
    .channel(ch_act), .code(core));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] exp_res(input logic [4:0] c, input logic h, input int k);
    logic [9:0] s;
    s = {c, c};
    return h ? 16'(s[9:2]) * 16'(k) : 16'(s) * 16'(k);
  endfunction
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task tmo(input int k);
    if (k >= 3000) begin
      check(1'b0, "wait ran out");
      finish_test();
    end
  endtask
  task bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task bus_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // waits while the level of a design output equals lvl; halt pulses at cycles 5 to 14
  task wait_while(input logic lvl, input logic hp, output int k);
    k = 0;
    while ((lvl ? busy : ~busy) === 1'b1 && k < 3000) begin
      @(posedge clk);
      #1 k++;
      halt <= hp && k >= 5 && k < 15;
    end
    tmo(k);
  endtask
  task wait_sh(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (sh !== 1'b1 && k < 3000);
    tmo(k);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    {addr, wdata, wr, rd, ev, halt} = '0;
    lf = 32'h304ec376;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      {ch, dl, ln} = {lf[4:0], 2'b00, lf[9:8], 2'b00, lf[13:12]};
      {dbg, r8, pr} = {i[0], i[1], 3'(i / 2)};
      bus_wr(OFS_CHAN, 16'(ch));
      // only fast prescales keep the run short; full-resolution rates are left to software
      bus_wr(OFS_CLKDIV, 16'(pr));
      bus_wr(OFS_SAMPLE, {8'h00, ln, dl});
      bus_wr(OFS_CTRL, {12'h000, dbg, r8, 2'b01});
      bus_wr(OFS_COMMAND, 16'h0001);
      wait_while(1'b0, 1'b0, lat);
      // k counts from the edge that took the write, so the write cycle adds one
      check(lat + 1 == (1 << pr) + 2, "start latency");
      wait_while(1'b1, 1'b1, len);
      check(len == (13 + dl + ln) * (2 << pr) + (dbg ? 0 : 10), "length");
      bus_rd(OFS_COMMAND, v);
      check(v[0] === 1'b0, "start bit kept");
      bus_rd(OFS_INTFLAG, v);
      check(v[0] === 1'b1, "flag not set");
      bus_rd(OFS_RESULT, v);
      check(v === exp_res(ch, r8, 1), "result");
      bus_rd(OFS_INTFLAG, v);
      check(v[0] === 1'b0, "flag not cleared by read");
    end
    $display("single conversions done");
    bus_wr(OFS_ACCUM, 16'h0001);
    bus_wr(OFS_INTCTRL, 16'h0001);
    bus_wr(OFS_EVCTRL, 16'h0001);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    for (n = 0; irq !== 1'b1 && n < 3000; n++) @(posedge clk);
    tmo(n);
    bus_wr(OFS_INTFLAG, 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    check(irq === 1'b0, "irq after flag clear");
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    for (n = 0; irq !== 1'b1 && n < 3000; n++) @(posedge clk);
    tmo(n);
    bus_rd(OFS_RESULT, v);
    check(v === exp_res(ch, r8, 2), "accumulated result");
    bus_wr(OFS_ACCUM, 16'h0000);
    bus_wr(OFS_EVCTRL, 16'h0000);
    $display("event and accumulation done");
    c2 = ~ch;
    bus_wr(OFS_CTRL, 16'h0003);
    bus_wr(OFS_REF, 16'h0005);
    bus_rd(OFS_REF, v);
    check(v === 16'h0005, "reference holding readback");
    check(ref_act === 3'h5, "reference copy while idle");
    bus_wr(OFS_COMMAND, 16'h0001);
    wait_sh(n);
    bus_wr(OFS_CHAN, 16'(c2));
    bus_rd(OFS_COMMAND, v);
    check(v[0] === 1'b1, "start bit low in free run");
    wait_sh(n);
    wait_sh(n);
    check(n == (13 + dl + ln) * (2 << pr), "free run period");
    check(ch_act === c2, "late channel change");
    bus_wr(OFS_CTRL, 16'h0001);
    wait_while(1'b1, 1'b0, n);
    bus_rd(OFS_RESULT, v);
    check(v === exp_res(c2, 1'b0, 1), "free run result");
    $display("free running done");
    bus_wr(OFS_COMMAND, 16'h0001);
    wait_sh(n);
    bus_wr(OFS_CTRL, 16'h0000);
    wait_while(1'b1, 1'b0, n);
    bus_rd(OFS_INTFLAG, v);
    check(v[0] === 1'b0, "flag after abandon");
    bus_rd(OFS_RESULT, v);
    check(v === exp_res(c2, 1'b0, 1), "result after abandon");
    bus_rd(OFS_COMMAND, v);
    check(v[0] === 1'b0, "start bit after abandon");
    $display("abandon done");
    finish_test();
  end
endmodule // sacc_top_tb
`default_nettype wire
